/* rtl/dssi_pkg.sv */
/*
 * Constants shared by the spindle start/stop and seek interlock block.
 * Assumes a single 100 MHz logic clock and 32-bit APB register access.
 */
// Behaviour
// (R1) Spindle runs only with switch in run and operating power present.
// (R2) Door variants also need a closed door and seated cartridge.
// (R3) Run gate enabled only while supply-good is true.
// (R4) Wait eight seconds after spindle start before head load.
// (R5) Start-delay counter counts one tick per second, holds at eight.
// (R6) Head load is on-speed AND saturated start-delay counter.
// (R7) Head load arms ready flop and drives heads to cylinder zero.
// (R8) Settled at cylinder zero gives on-cylinder, which sets ready.
// (R9) Ready drives the ready line and lamp and allows operations.
// (R10) Stop on switch to load, speed loss, or bus power loss.
// (R11) Stop withdraws head load and drops ready; heads retract.
// (R12) Spindle turns off only after heads are fully home.
// (R13) After rotation stops, light load lamp and release door lock.
// (R14) Seek address above 202 answers invalid, no head motion.
// (R15) Valid address answers accepted and computes cylinder difference.
// (R16) Each crossing pulse updates difference register selecting velocity.
// (R17) After stop at target and settle delay, assert on-cylinder.
// (R18) Restore or inner limit during seek aborts and returns to zero.
// (R19) Double-frequency coding: clock reversal each cell, mid-cell reversal for one.
// (R20) Controller raises strobe after address settles, holds until answered.
// (R21) Controller holds address lines stable until answered.
// (R22) Answer is one low pulse about 2 us after strobe, always; the code answers only while drive_ready is set and no answer is running.
// (R23) On-cylinder true only while ready and not seeking.
// (R24) Slow tick and delays counted from logic clock; reset clears state.
// (R25) Asynchronous pins synchronised before use.
package dssi_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned SLOW_TICK_MS    = 1000;
   localparam int unsigned SPEED_LIMIT_MS  = 50;
   localparam int unsigned SETTLE_US       = 200;
   localparam int unsigned ANSWER_DELAY_US = 2;
   localparam int unsigned ANSWER_WIDTH_US = 5;
   localparam int unsigned SLOW_TICK_CYC   = CLK_HZ / 1000 * SLOW_TICK_MS;
   localparam int unsigned SPEED_LIMIT_CYC = CLK_HZ / 1000 * SPEED_LIMIT_MS;
   localparam int unsigned SETTLE_CYC      = CLK_HZ / 1_000_000 * SETTLE_US;
   localparam int unsigned ANSWER_DLY_CYC  = CLK_HZ / 1_000_000 * ANSWER_DELAY_US;
   localparam int unsigned ANSWER_WID_CYC  = CLK_HZ / 1_000_000 * ANSWER_WIDTH_US;
   localparam logic [3:0]  START_DELAY_SAT = 4'h8;
   localparam logic [1:0]  STOPPED_SAT     = 2'h2;
   localparam logic [7:0]  MAX_CYLINDER    = 8'hCA;
   localparam logic [7:0]  FAST_DIFF_MIN   = 8'h04;
   localparam logic [11:0] ADDR_CTRL       = 12'h000;
   localparam logic [11:0] ADDR_STATUS     = 12'h004;
   localparam logic [11:0] ADDR_CYL        = 12'h008;
   localparam int unsigned CTRL_RUN_BIT    = 0;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
   typedef enum logic [2:0] {
      DSSI_IDLE, DSSI_SPIN, DSSI_LOADED, DSSI_RETRACT, DSSI_COAST
   } dssi_state_t;
endpackage : dssi_pkg

/* rtl/dssi_top.sv */
/*
 * Start/stop interlock sequencer, seek address check and handshake,
 * difference register and double-frequency write encoder.
 * Assumes pins arrive asynchronously and a controller that holds
 * strobe and address until it sees the answer pulse.
 */
`timescale 1ns/100ps
module dssi_top
   import dssi_pkg::*;
#(
   parameter bit          DOOR_VARIANT = 1'b1,
   parameter int unsigned TICK_CYC     = SLOW_TICK_CYC,
   parameter int unsigned SPEED_CYC    = SPEED_LIMIT_CYC,
   parameter int unsigned SETTLE_CYCS  = SETTLE_CYC,
   parameter int unsigned HALF_CELL    = 8
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        run_switch,
   input  wire logic        door_closed,
   input  wire logic        cartridge_seated,
   input  wire logic        supply_good,
   input  wire logic        bus_power_good,
   input  wire logic        index_pulse,
   input  wire logic        heads_home,
   input  wire logic        cyl_crossing,
   input  wire logic        inner_limit,
   input  wire logic        seek_strobe,
   input  wire logic        restore_req,
   input  wire logic [7:0]  cyl_addr,
   input  wire logic        wr_cell_strobe,
   input  wire logic        wr_data_bit,
   output logic             spindle_on,
   output logic             head_load,
   output logic             drive_ready,
   output logic             ready_lamp,
   output logic             on_cylinder_line,
   output logic             on_cylinder_lamp,
   output logic             load_lamp,
   output logic             door_unlock,
   output logic             addr_accepted_n,
   output logic             addr_invalid_n,
   output logic             return_to_zero_cmd,
   output logic             seek_forward,
   output logic             seek_fast,
   output logic      [7:0]  seek_diff,
   output logic             wr_flux
);
   localparam int unsigned NPIN = 21;

   function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
      absdiff = (a > b) ? 8'(a - b) : 8'(b - a);
   endfunction : absdiff

   logic [NPIN-1:0] sync1_ff, sync2_ff, prev_ff;
   // (R25) Two-stage pin synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff  <= '0;
      end else begin
         sync1_ff <= {wr_data_bit, wr_cell_strobe, cyl_addr, restore_req, seek_strobe,
                      inner_limit, cyl_crossing, heads_home, index_pulse, bus_power_good,
                      supply_good, cartridge_seated, door_closed, run_switch};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   logic       s_run, s_door, s_cart, s_supply, s_buspwr, s_home, s_inner, s_restore;
   logic       s_wbit, index_rise, cross_rise, strobe_rise, cell_rise;
   logic [7:0] s_addr;
   assign s_run       = sync2_ff[0];
   assign s_door      = sync2_ff[1];
   assign s_cart      = sync2_ff[2];
   assign s_supply    = sync2_ff[3];
   assign s_buspwr    = sync2_ff[4];
   assign index_rise  = sync2_ff[5] & ~prev_ff[5];
   assign s_home      = sync2_ff[6];
   assign cross_rise  = sync2_ff[7] & ~prev_ff[7];
   assign s_inner     = sync2_ff[8];
   assign strobe_rise = sync2_ff[9] & ~prev_ff[9];
   assign s_restore   = sync2_ff[10];
   assign s_addr      = sync2_ff[18:11];
   assign cell_rise   = sync2_ff[19] & ~prev_ff[19];
   assign s_wbit      = sync2_ff[20];

   logic [31:0] ctrl_ff;
   logic        run_gate, stop_req;
   // (R1) Switch and power. (R2) Door and cartridge on door variants. (R3) Supply good.
   assign run_gate = s_run & s_supply & s_buspwr & ctrl_ff[CTRL_RUN_BIT]
                     & (~DOOR_VARIANT | (s_door & s_cart));

   // (R24) One-second slow tick from the logic clock.
   logic [31:0] tick_cnt_ff;
   logic        tick_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b0;
      end else begin
         tick_ff     <= (tick_cnt_ff == 32'(TICK_CYC - 1));
         tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 32'h1;
      end
   end

   // (R10) Speed supervision: index pulses must keep arriving.
   logic [31:0] speed_cnt_ff;
   logic        on_speed_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_cnt_ff <= '0;
         on_speed_ff  <= 1'b0;
      end else if (index_rise) begin
         speed_cnt_ff <= '0;
         on_speed_ff  <= 1'b1;
      end else if (speed_cnt_ff == 32'(SPEED_CYC - 1)) begin
         on_speed_ff  <= 1'b0;
      end else begin
         speed_cnt_ff <= speed_cnt_ff + 32'h1;
      end
   end

   dssi_state_t state_ff;
   logic [3:0]  start_cnt_ff;
   logic [1:0]  stop_cnt_ff;
   logic        start_sat, seeking_ff, settled_ff, nxt_head_load;
   assign start_sat = (start_cnt_ff == START_DELAY_SAT);
   // (R10) Any of the three stop causes.
   assign stop_req  = ~run_gate | ~on_speed_ff;

   // (R4) Spin-up delay. (R5) Counts ticks and saturates at eight.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_cnt_ff <= '0;
      end else if (!run_gate || (head_load && !on_speed_ff)) begin
         start_cnt_ff <= '0;
      end else if (tick_ff && !start_sat) begin
         start_cnt_ff <= start_cnt_ff + 4'h1;
      end
   end

   // (R12) Spindle sequencing. (R13) Stopped detection by absent index pulses.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= DSSI_IDLE;
         stop_cnt_ff <= '0;
      end else begin
         unique case (state_ff)
            DSSI_IDLE, DSSI_COAST: begin
               if (run_gate) begin
                  state_ff <= DSSI_SPIN;
               end else if (index_rise) begin
                  stop_cnt_ff <= '0;
               end else if (tick_ff && stop_cnt_ff != STOPPED_SAT) begin
                  stop_cnt_ff <= stop_cnt_ff + 2'h1;
               end
            end
            DSSI_SPIN: begin
               if (!run_gate) begin
                  state_ff <= DSSI_RETRACT;
               end else if (head_load) begin
                  state_ff <= DSSI_LOADED;
               end
            end
            DSSI_LOADED: begin
               if (stop_req) begin
                  state_ff <= DSSI_RETRACT;
               end
            end
            DSSI_RETRACT: begin
               if (s_home) begin
                  state_ff    <= DSSI_COAST;
                  stop_cnt_ff <= '0;
               end
            end
         endcase
      end
   end

   // (R1) Spindle on from spin-up until heads home. (R12) Off after retract.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spindle_on  <= 1'b0;
         load_lamp   <= 1'b0;
         door_unlock <= 1'b0;
      end else begin
         spindle_on  <= (state_ff == DSSI_SPIN) || (state_ff == DSSI_LOADED)
                        || (state_ff == DSSI_RETRACT && !s_home);
         // (R13) Load lamp and door release once rotation has ceased.
         load_lamp   <= (state_ff == DSSI_IDLE || state_ff == DSSI_COAST)
                        && stop_cnt_ff == STOPPED_SAT;
         door_unlock <= DOOR_VARIANT && (state_ff == DSSI_IDLE || state_ff == DSSI_COAST)
                        && stop_cnt_ff == STOPPED_SAT;
      end
   end

   // (R6) Head load is on-speed AND saturated delay. (R11) Withdrawn on stop.
   assign nxt_head_load = on_speed_ff && start_sat && run_gate
                          && (state_ff == DSSI_SPIN || state_ff == DSSI_LOADED);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head_load <= 1'b0;
      end else begin
         head_load <= nxt_head_load;
      end
   end

   // (R7) Ready flop armed by head load. (R8) Set by settled at zero.
   // (R9) Ready line and lamp. (R11) Dropped on head-load removal.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_ready <= 1'b0;
         ready_lamp  <= 1'b0;
      end else if (!nxt_head_load) begin
         drive_ready <= 1'b0;
         ready_lamp  <= 1'b0;
      end else if (settled_ff && !seeking_ff) begin
         drive_ready <= 1'b1;
         ready_lamp  <= 1'b1;
      end
   end

   // Seek handshake: decide at strobe, answer later with a low pulse.
   logic [9:0]  ans_cnt_ff;
   logic        ans_busy_ff, ans_valid_ff, ans_rtz_ff;
   logic [7:0]  ans_addr_ff;
   // (R20) Strobe edge taken after address settles. (R21) Address latched.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ans_cnt_ff      <= '0;
         ans_busy_ff     <= 1'b0;
         ans_valid_ff    <= 1'b0;
         ans_rtz_ff      <= 1'b0;
         ans_addr_ff     <= '0;
         addr_accepted_n <= 1'b1;
         addr_invalid_n  <= 1'b1;
      end else if (strobe_rise && !ans_busy_ff && drive_ready) begin
         ans_busy_ff  <= 1'b1;
         ans_cnt_ff   <= '0;
         ans_rtz_ff   <= s_restore;
         ans_addr_ff  <= s_addr;
         // (R14) Above the top cylinder is invalid. (R15) Else accepted.
         ans_valid_ff <= s_restore || (s_addr <= MAX_CYLINDER);
      end else if (ans_busy_ff) begin
         ans_cnt_ff <= ans_cnt_ff + 10'h1;
         // (R22) One low pulse, delayed, issued even for same cylinder.
         if (ans_cnt_ff == 10'(ANSWER_DLY_CYC - 1)) begin
            addr_accepted_n <= ~ans_valid_ff;
            addr_invalid_n  <= ans_valid_ff;
         end else if (ans_cnt_ff == 10'(ANSWER_DLY_CYC + ANSWER_WID_CYC - 1)) begin
            addr_accepted_n <= 1'b1;
            addr_invalid_n  <= 1'b1;
            ans_busy_ff     <= 1'b0;
         end
      end
   end

   logic       seek_go, abort;
   logic [7:0] cur_cyl_ff, tgt_cyl_ff;
   logic [31:0] settle_cnt_ff;
   assign seek_go = ans_busy_ff && ans_valid_ff && ans_cnt_ff == 10'(ANSWER_DLY_CYC - 1);
   assign abort   = seeking_ff && !return_to_zero_cmd && (s_restore || s_inner);

   // (R15) Difference and direction from new and current cylinder.
   // (R16) Crossing pulses update difference. (R18) Abort to zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_cyl_ff         <= '0;
         tgt_cyl_ff         <= '0;
         seek_diff          <= '0;
         seek_forward       <= 1'b0;
         seek_fast          <= 1'b0;
         seeking_ff         <= 1'b0;
         return_to_zero_cmd <= 1'b0;
      end else if (!head_load) begin
         cur_cyl_ff         <= '0;
         tgt_cyl_ff         <= '0;
         seek_diff          <= '0;
         seek_fast          <= 1'b0;
         seeking_ff         <= 1'b0;
         return_to_zero_cmd <= 1'b0;
      end else if (abort || (seek_go && ans_rtz_ff)) begin
         tgt_cyl_ff         <= '0;
         seek_diff          <= cur_cyl_ff;
         seek_forward       <= 1'b0;
         seek_fast          <= cur_cyl_ff >= FAST_DIFF_MIN;
         seeking_ff         <= 1'b1;
         return_to_zero_cmd <= 1'b1;
      end else if (seek_go) begin
         tgt_cyl_ff   <= ans_addr_ff;
         seek_diff    <= absdiff(ans_addr_ff, cur_cyl_ff);
         seek_forward <= ans_addr_ff > cur_cyl_ff;
         seek_fast    <= absdiff(ans_addr_ff, cur_cyl_ff) >= FAST_DIFF_MIN;
         seeking_ff   <= 1'b1;
      end else if (seeking_ff && seek_diff == '0 && settled_ff) begin
         seeking_ff         <= 1'b0;
         return_to_zero_cmd <= 1'b0;
      end else if (seeking_ff && cross_rise && seek_diff != '0) begin
         seek_diff  <= seek_diff - 8'h1;
         seek_fast  <= (seek_diff - 8'h1) >= FAST_DIFF_MIN;
         cur_cyl_ff <= seek_forward ? cur_cyl_ff + 8'h1 : cur_cyl_ff - 8'h1;
      end
   end

   // (R17) Settle delay once heads stand still at target or zero.
   // (R24) Delay counted in logic clock cycles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt_ff <= '0;
         settled_ff    <= 1'b0;
      end else if (!head_load || seek_go || abort || seek_diff != '0 || cross_rise) begin
         settle_cnt_ff <= '0;
         settled_ff    <= 1'b0;
      end else if (settle_cnt_ff == 32'(SETTLE_CYCS - 1)) begin
         settled_ff    <= 1'b1;
      end else begin
         settle_cnt_ff <= settle_cnt_ff + 32'h1;
      end
   end

   // (R8) On-cylinder at zero sets ready. (R23) Only when ready and idle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_cylinder_line <= 1'b0;
         on_cylinder_lamp <= 1'b0;
      end else begin
         on_cylinder_line <= nxt_head_load && !seeking_ff && settled_ff && !seek_go && !abort;
         on_cylinder_lamp <= nxt_head_load && !seeking_ff && settled_ff && !seek_go && !abort;
      end
   end

   // (R19) Double-frequency writer: reversal at cell edge, mid-cell for one.
   logic [7:0] cell_cnt_ff;
   logic       cell_bit_ff, cell_mid_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_flux     <= 1'b0;
         cell_cnt_ff <= '0;
         cell_bit_ff <= 1'b0;
         cell_mid_ff <= 1'b0;
      end else if (cell_rise) begin
         wr_flux     <= ~wr_flux;
         cell_bit_ff <= s_wbit;
         cell_mid_ff <= 1'b1;
         cell_cnt_ff <= '0;
      end else if (cell_mid_ff) begin
         cell_cnt_ff <= cell_cnt_ff + 8'h1;
         if (cell_cnt_ff == 8'(HALF_CELL - 1)) begin
            cell_mid_ff <= 1'b0;
            wr_flux     <= wr_flux ^ cell_bit_ff;
         end
      end
   end

   // APB slave: zero wait, answer prepared during the setup cycle.
   logic [31:0] rd_val;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_val = '0;
      unique case (paddr)
         ADDR_CTRL:   rd_val = ctrl_ff;
         ADDR_STATUS: rd_val = {16'h0000, 6'h00, state_ff, on_speed_ff, seeking_ff,
                                drive_ready, head_load, spindle_on, load_lamp, start_cnt_ff[3]};
         ADDR_CYL:    rd_val = {8'h00, seek_diff, tgt_cyl_ff, cur_cyl_ff};
         default:     rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !rd_hit;
         prdata  <= (psel && !penable && !pwrite) ? rd_val : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
         ctrl_ff <= {31'h0, pwdata[CTRL_RUN_BIT]};
      end
   end
endmodule : dssi_top

/* verif/dssi_chk.sv */
/* Checker for the interlock block ports.
   Assumes it is bound into the top module and sees only its ports. */
`timescale 1ns/100ps
module dssi_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic seek_strobe,
   input wire logic run_switch,
   input wire logic door_closed,
   input wire logic cartridge_seated,
   input wire logic supply_good,
   input wire logic bus_power_good,
   input wire logic heads_home,
   input wire logic spindle_on,
   input wire logic head_load,
   input wire logic drive_ready,
   input wire logic ready_lamp,
   input wire logic on_cylinder_line,
   input wire logic on_cylinder_lamp,
   input wire logic load_lamp,
   input wire logic door_unlock,
   input wire logic addr_accepted_n,
   input wire logic addr_invalid_n
);
   logic [9:0] lo_cnt_ff;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_cnt_ff <= 10'h000;
      end else begin
         lo_cnt_ff <= (addr_accepted_n && addr_invalid_n) ? 10'h000 : lo_cnt_ff + 10'h001;
      end
   end
   chk_spin_gate: assert property (
      $rose(spindle_on) |-> run_switch && door_closed && cartridge_seated && supply_good
      && bus_power_good) else $error("spindle started without run conditions");
   chk_load_spin: assert property (
      head_load |-> spindle_on) else $error("head load without spindle");
   chk_ready_load: assert property (
      drive_ready |-> head_load) else $error("ready without head load");
   chk_ready_lamp: assert property (
      ready_lamp == drive_ready) else $error("ready lamp differs from line");
   chk_oncyl_ready: assert property (
      on_cylinder_line |-> drive_ready) else $error("on cylinder while not ready");
   chk_oncyl_lamp: assert property (
      on_cylinder_lamp == on_cylinder_line) else $error("on cylinder lamp differs");
   chk_answer_width: assert property (
      $rose(addr_accepted_n && addr_invalid_n) |-> lo_cnt_ff == 10'h1F4)
      else $error("answer pulse width wrong");
   chk_one_answer: assert property (
      !(!addr_accepted_n && !addr_invalid_n)) else $error("both answers low");
   chk_answer_strobe: assert property (
      $fell(addr_accepted_n && addr_invalid_n) |-> $past(seek_strobe, 150))
      else $error("answer too early after strobe");
   chk_spin_home: assert property (
      $fell(spindle_on) |-> heads_home) else $error("spindle off before heads home");
   chk_door_stop: assert property (
      door_unlock |-> !spindle_on && load_lamp) else $error("door released while spinning");
   cov_accept: cover property ($fell(addr_accepted_n));
   cov_invalid: cover property ($fell(addr_invalid_n));
   cov_unlock: cover property ($rose(door_unlock));
endmodule : dssi_chk
bind dssi_top dssi_chk dssi_chk_inst (.*);

/* verif/dssi_ctl_model.sv */
/* Disk controller model for the seek handshake.
   Assumes go pulses for one clock while no answer runs. */
`timescale 1ns/100ps
module dssi_ctl_model (
   input  wire logic       pclk,
   input  wire logic       go,
   input  wire logic [7:0] addr_in,
   input  wire logic       rtz_in,
   input  wire logic       slow,
   input  wire logic       acc_n,
   input  wire logic       inv_n,
   output logic            seek_strobe,
   output logic      [7:0] cyl_addr,
   output logic            restore_req
);
   initial begin
      seek_strobe = 1'b0;
      cyl_addr = 8'h00;
      restore_req = 1'b0;
      forever begin
         @(posedge pclk);
         if (go === 1'b1) begin
            cyl_addr <= addr_in;
            restore_req <= rtz_in;
            repeat (slow ? 40 : 4) @(posedge pclk);
            seek_strobe <= 1'b1;
            do @(posedge pclk); while (acc_n === 1'b1 && inv_n === 1'b1);
            seek_strobe <= 1'b0;
            restore_req <= 1'b0;
            cyl_addr <= ~cyl_addr;
         end
      end
   end
endmodule : dssi_ctl_model

/* verif/dssi_tb_top.sv */
/* Bench for the interlock block: APB tasks, pin stimulus, controller model.
   Assumes shortened tick, speed and settle counts. */
`timescale 1ns/100ps
module dssi_tb_top;
   import dssi_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        run_switch, door_closed, cartridge_seated, supply_good, bus_power_good;
   logic        index_pulse, heads_home, cyl_crossing, inner_limit, seek_strobe;
   logic        restore_req, wr_cell_strobe, wr_data_bit, spindle_on, head_load;
   logic        drive_ready, ready_lamp, on_cylinder_line, on_cylinder_lamp, load_lamp;
   logic        door_unlock, addr_accepted_n, addr_invalid_n, return_to_zero_cmd;
   logic        seek_forward, seek_fast, wr_flux, c_go, c_rtz, c_slow, spin_en, flux_ff = 1'b0;
   logic [7:0]  cyl_addr, seek_diff, c_addr;
   int          err_total, check_count, flips = 0, icnt = 0, f0;
   dssi_top #(.TICK_CYC(100), .SPEED_CYC(60), .SETTLE_CYCS(10)) dssi_top_inst (.*);
   dssi_ctl_model dssi_ctl_model_inst (.pclk, .go(c_go), .addr_in(c_addr), .rtz_in(c_rtz),
      .slow(c_slow), .acc_n(addr_accepted_n), .inv_n(addr_invalid_n), .seek_strobe,
      .cyl_addr, .restore_req);
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      icnt <= (icnt == 29) ? 0 : icnt + 1;
      index_pulse <= spin_en && icnt < 4;
      flux_ff <= wr_flux;
      if (flux_ff !== wr_flux) flips <= flips + 1;
   end
   task results;
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task hang;
      err_total++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      results;
   endtask : hang
   function automatic logic sig(input int s);
      case (s)
         0: return drive_ready;
         1: return head_load;
         2: return on_cylinder_line;
         3: return addr_accepted_n && addr_invalid_n;
         4: return spindle_on;
         default: return load_lamp;
      endcase
   endfunction : sig
   task await(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) hang;
   endtask : await
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) hang;
      @(posedge pclk);
   endtask : apb
   task xing(input int k);
      repeat (k) begin
         cyl_crossing <= 1'b1;
         repeat (4) @(posedge pclk);
         cyl_crossing <= 1'b0;
         repeat (6) @(posedge pclk);
      end
   endtask : xing
   task dbit(input logic b);
      wr_data_bit <= b;
      repeat (4) @(posedge pclk);
      wr_cell_strobe <= 1'b1;
      repeat (4) @(posedge pclk);
      wr_cell_strobe <= 1'b0;
      repeat (24) @(posedge pclk);
   endtask : dbit
   task seek(input logic [7:0] a, input logic r, input logic s, input logic inv);
      await(3, 1'b1, 700);
      c_addr <= a;
      c_rtz <= r;
      c_slow <= s;
      c_go <= 1'b1;
      @(posedge pclk);
      c_go <= 1'b0;
      await(3, 1'b0, 1200);
      chk({30'h0, addr_accepted_n, addr_invalid_n}, inv ? 32'h2 : 32'h1);
      repeat (3) @(posedge pclk);
   endtask : seek
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {run_switch, door_closed, cartridge_seated, supply_good, bus_power_good} = '0;
      {cyl_crossing, inner_limit, wr_cell_strobe, wr_data_bit, c_go, c_rtz} = '0;
      {c_slow, spin_en, c_addr, err_total, check_count} = '0;
      heads_home = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, CTRL_RESET);
      apb(1'b0, 12'h00C, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, ADDR_CTRL, CTRL_RESET);
      f0 = flips;
      dbit(1'b1);
      dbit(1'b0);
      dbit(1'b1);
      dbit(1'b1);
      chk(flips - f0, 7);
      {run_switch, cartridge_seated, bus_power_good, supply_good} <= 4'hF;
      repeat (40) @(posedge pclk);
      chk({31'h0, spindle_on}, 32'h0);
      door_closed <= 1'b1;
      supply_good <= 1'b0;
      repeat (40) @(posedge pclk);
      chk({31'h0, spindle_on}, 32'h0);
      supply_good <= 1'b1;
      spin_en <= 1'b1;
      await(4, 1'b1, 20);
      repeat (650) @(posedge pclk);
      chk({31'h0, head_load}, 32'h0);
      await(1, 1'b1, 400);
      await(0, 1'b1, 200);
      chk({29'h0, ready_lamp, on_cylinder_line, on_cylinder_lamp}, 32'h7);
      heads_home <= 1'b0;
      seek(8'h03, 1'b0, 1'b0, 1'b0);
      chk({22'h0, on_cylinder_line, seek_forward, seek_diff}, 32'h103);
      xing(3);
      await(2, 1'b1, 100);
      chk({24'h0, seek_diff}, 32'h0);
      seek(8'h03, 1'b0, 1'b1, 1'b0);
      await(2, 1'b1, 100);
      seek(8'hCB, 1'b0, 1'b0, 1'b1);
      chk({23'h0, on_cylinder_line, seek_diff}, 32'h100);
      seek(8'hFF, 1'b0, 1'b0, 1'b1);
      seek(MAX_CYLINDER, 1'b0, 1'b0, 1'b0);
      chk({22'h0, seek_fast, seek_forward, seek_diff}, 32'h3C7);
      xing(2);
      chk({24'h0, seek_diff}, 32'hC5);
      seek(8'h00, 1'b1, 1'b0, 1'b0);
      chk({22'h0, return_to_zero_cmd, seek_forward, seek_diff}, 32'h205);
      run_switch <= 1'b0;
      await(1, 1'b0, 20);
      chk({29'h0, drive_ready, on_cylinder_line, spindle_on}, 32'h1);
      repeat (30) @(posedge pclk);
      chk({31'h0, spindle_on}, 32'h1);
      heads_home <= 1'b1;
      await(4, 1'b0, 20);
      repeat (300) @(posedge pclk);
      chk({30'h0, load_lamp, door_unlock}, 32'h0);
      spin_en <= 1'b0;
      await(5, 1'b1, 400);
      @(posedge pclk);
      chk({31'h0, door_unlock}, 32'h1);
      results;
   end
endmodule : dssi_tb_top
